//--- core/axi3_avalon_interconnect_adapt.sv
// axi3 and avalon masters to axi and avalon slaves, serial ordered engine
//
// Our own choices: the address map and the plain strobed port.
`include "axi_av_cfg.svh"
//
// Summary of operation
// - address channels carry 64-bit addresses and ids up to 18 bits
// - data paths 32 bits wide, built from 8-bit byte lanes
// - cache attributes go to the axi slave unaltered
// - every write response to an axi master from the axi slave comes from that final target slave
// - avalon slave write response made once the slave accepts the write
// - non-modifiable commands to the axi slave keep address, length and size
// - axi bursts to avalon slave split into several avalon accesses
// - avalon master commands carry zero cache and allocate bits
// - protection bits pass unchanged and steer nothing
// - lock, id and response carried through for exclusive access
// - avalon slaves answer okay, locked access unsupported
// - responses return in issue order per master
// - reordering slaves see id zero, others the master id
// - master outstanding to one slave only; other slave stalls
// - strict option holds avalon reads until write responses return
// - commands to avalon slave aligned to its data width
// - avalon byte enables contiguous, axi strobes any pattern
// - byte lane zero sits on bits 7 to 0
// - reads split per beat, byte enables from size, address rounded down
module axi3_avalon_interconnect_adapt (
  input  wire logic                 mclk_i,
  input  wire logic                 resetn_i,
  // axi3 master facing ports
  input  wire logic                 s_awvalid_i,
  input  wire axi_av_pkg::id_t      s_awid_i,
  input  wire axi_av_pkg::addr_t    s_awaddr_i,
  input  wire logic [3:0]           s_awlen_i,
  input  wire logic [2:0]           s_awsize_i,
  input  wire logic [1:0]           s_awburst_i,
  input  wire logic [1:0]           s_awlock_i,
  input  wire logic [3:0]           s_awcache_i,
  input  wire logic [2:0]           s_awprot_i,
  output logic                      s_awready_o,
  input  wire logic                 s_wvalid_i,
  input  wire logic [`DW-1:0]       s_wdata_i,
  input  wire logic [`SW-1:0]       s_wstrb_i,
  input  wire logic                 s_wlast_i,
  output logic                      s_wready_o,
  output logic                      s_bvalid_o,
  output axi_av_pkg::id_t           s_bid_o,
  output logic [1:0]                s_bresp_o,
  input  wire logic                 s_bready_i,
  input  wire logic                 s_arvalid_i,
  input  wire axi_av_pkg::id_t      s_arid_i,
  input  wire axi_av_pkg::addr_t    s_araddr_i,
  input  wire logic [3:0]           s_arlen_i,
  input  wire logic [2:0]           s_arsize_i,
  input  wire logic [1:0]           s_arburst_i,
  input  wire logic [1:0]           s_arlock_i,
  input  wire logic [3:0]           s_arcache_i,
  input  wire logic [2:0]           s_arprot_i,
  output logic                      s_arready_o,
  output logic                      s_rvalid_o,
  output axi_av_pkg::id_t           s_rid_o,
  output logic [`DW-1:0]            s_rdata_o,
  output logic [1:0]                s_rresp_o,
  output logic                      s_rlast_o,
  input  wire logic                 s_rready_i,
  // axi slave facing ports
  output logic                      m_awvalid_o,
  output axi_av_pkg::id_t           m_awid_o,
  output axi_av_pkg::addr_t         m_awaddr_o,
  output logic [3:0]                m_awlen_o,
  output logic [2:0]                m_awsize_o,
  output logic [1:0]                m_awburst_o,
  output logic [1:0]                m_awlock_o,
  output logic [3:0]                m_awcache_o,
  output logic [2:0]                m_awprot_o,
  input  wire logic                 m_awready_i,
  output logic                      m_wvalid_o,
  output logic [`DW-1:0]            m_wdata_o,
  output logic [`SW-1:0]            m_wstrb_o,
  output logic                      m_wlast_o,
  input  wire logic                 m_wready_i,
  input  wire logic                 m_bvalid_i,
  input  wire logic [1:0]           m_bresp_i,
  output logic                      m_bready_o,
  output logic                      m_arvalid_o,
  output axi_av_pkg::id_t           m_arid_o,
  output axi_av_pkg::addr_t         m_araddr_o,
  output logic [3:0]                m_arlen_o,
  output logic [2:0]                m_arsize_o,
  output logic [1:0]                m_arburst_o,
  output logic [1:0]                m_arlock_o,
  output logic [3:0]                m_arcache_o,
  output logic [2:0]                m_arprot_o,
  input  wire logic                 m_arready_i,
  input  wire logic                 m_rvalid_i,
  input  wire logic [`DW-1:0]       m_rdata_i,
  input  wire logic [1:0]           m_rresp_i,
  output logic                      m_rready_o,
  // avalon master facing ports
  input  wire logic [`AVW-1:0]      am_address_i,
  input  wire logic                 am_read_i,
  input  wire logic                 am_write_i,
  input  wire logic [`DW-1:0]       am_writedata_i,
  input  wire logic [`SW-1:0]       am_byteenable_i,
  output logic                      am_waitrequest_o,
  output logic [`DW-1:0]            am_readdata_o,
  output logic                      am_readdatavalid_o,
  // avalon slave facing ports
  output logic [`AVW-1:0]           av_address_o,
  output logic                      av_read_o,
  output logic                      av_write_o,
  output logic [`DW-1:0]            av_writedata_o,
  output logic [`SW-1:0]            av_byteenable_o,
  input  wire logic                 av_waitrequest_i,
  input  wire logic [`DW-1:0]       av_readdata_i,
  input  wire logic                 av_readdatavalid_i
);
  // ==========================================================
  // declarations
  axi_av_pkg::eng_st_t st_r;
  axi_av_pkg::addr_t   addr_r;
  axi_av_pkg::addr_t   x_addr_r;
  axi_av_pkg::addr_t   c_addr;
  axi_av_pkg::id_t     id_r;
  axi_av_pkg::id_t     x_id_r;
  axi_av_pkg::id_t     c_id;
  logic [3:0]          cnt_r, x_len_r, c_len, x_cache_r, c_cache;
  logic [2:0]          size_r, x_size_r, c_size, x_prot_r, c_prot;
  logic [1:0]          burst_r, x_burst_r, c_burst, x_lock_r, c_lock;
  logic                src_axi_r, wr_r, tgt_lav_r;
  logic                idle, pk_aw, pk_ar, pk_am, am_go, c_wr, c_lav;
  trk_if               tk ();

  // byte enables follow the command size, lane picked by the size-aligned address
  function automatic logic [`SW-1:0] be_of(input logic [2:0] sz, input logic [1:0] a);
    case (sz)
      3'h0:    be_of = 4'h1 << a;
      3'h1:    be_of = 4'h3 << {a[1], 1'b0};
      default: be_of = 4'hf;
    endcase
  endfunction : be_of

  // address of the following beat: fixed bursts stay, others step by size
  function automatic axi_av_pkg::addr_t next_addr(input axi_av_pkg::addr_t a, input logic [2:0] sz,
                                                  input logic [1:0] bt);
    axi_av_pkg::addr_t step;
    step = `AW'(1) << sz;
    if (bt == `BURST_FIXED) begin
      next_addr = a;
    end else begin
      next_addr = (a & ~(step - `AW'(1))) + step;
    end
  endfunction : next_addr

  // ==========================================================
  // command pick: axi write, then axi read, then avalon master
  always_comb begin
    idle  = (st_r == axi_av_pkg::ST_IDLE);
    am_go = (am_read_i || am_write_i) && am_waitrequest_o && !tk.stall && !tk.full
            && !((`STRICT_ORD != 0) && am_read_i && tk.pend_nz);
    pk_aw = idle && !tk.pend_nz && s_awvalid_i;
    pk_ar = idle && !tk.pend_nz && !s_awvalid_i && s_arvalid_i;
    pk_am = idle && !pk_aw && !pk_ar && !s_awvalid_i && !s_arvalid_i && am_go;
    if (pk_aw) begin
      c_wr = 1'b1; c_addr = s_awaddr_i; c_id = s_awid_i; c_len = s_awlen_i;
      c_size = s_awsize_i; c_burst = s_awburst_i; c_lock = s_awlock_i;
      c_cache = s_awcache_i; c_prot = s_awprot_i;
    end else if (pk_ar) begin
      c_wr = 1'b0; c_addr = s_araddr_i; c_id = s_arid_i; c_len = s_arlen_i;
      c_size = s_arsize_i; c_burst = s_arburst_i; c_lock = s_arlock_i;
      c_cache = s_arcache_i; c_prot = s_arprot_i;
    end else begin
      // avalon master: single beat, full width, no cache or allocate bits
      c_wr = am_write_i; c_addr = {{(`AW - `AVW){1'b0}}, am_address_i}; c_id = '0;
      c_len = 4'h0; c_size = `AM_SIZE; c_burst = `BURST_INCR; c_lock = `LOCK_NONE;
      c_cache = `AM_CACHE; c_prot = `AM_PROT;
    end
    c_lav = c_addr[`TGT_BIT];
  end

  // ==========================================================
  // tracker of avalon master writes whose responses are still out
  assign tk.issue   = (st_r == axi_av_pkg::ST_XW) && m_wvalid_o && m_wready_i && m_wlast_o && !src_axi_r;
  assign tk.retire  = m_bvalid_i && m_bready_o && (st_r != axi_av_pkg::ST_XB);
  assign tk.tgt_lav = idle ? am_address_i[`TGT_BIT] : tgt_lav_r;

  out_tracker u_trk (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .tk       (tk)
  );

  // one attribute register set feeds both axi slave address channels
  assign m_awid_o    = x_id_r;
  assign m_arid_o    = x_id_r;
  assign m_awaddr_o  = x_addr_r;
  assign m_araddr_o  = x_addr_r;
  assign m_awlen_o   = x_len_r;
  assign m_arlen_o   = x_len_r;
  assign m_awsize_o  = x_size_r;
  assign m_arsize_o  = x_size_r;
  assign m_awburst_o = x_burst_r;
  assign m_arburst_o = x_burst_r;
  assign m_awlock_o  = x_lock_r;
  assign m_arlock_o  = x_lock_r;
  assign m_awcache_o = x_cache_r;
  assign m_arcache_o = x_cache_r;
  assign m_awprot_o  = x_prot_r;
  assign m_arprot_o  = x_prot_r;

  // ==========================================================
  // command engine: one command at a time, responses in order
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= axi_av_pkg::ST_IDLE;
      {src_axi_r, wr_r, tgt_lav_r} <= 3'h0;
      addr_r <= '0; id_r <= '0; cnt_r <= '0; size_r <= '0; burst_r <= '0;
      x_addr_r <= '0; x_id_r <= '0; x_len_r <= '0; x_size_r <= '0;
      x_burst_r <= '0; x_lock_r <= '0; x_cache_r <= '0; x_prot_r <= '0;
      {s_awready_o, s_arready_o, s_wready_o, s_bvalid_o, s_rvalid_o, s_rlast_o} <= 6'h0;
      s_bid_o <= '0; s_bresp_o <= '0; s_rid_o <= '0; s_rdata_o <= '0; s_rresp_o <= '0;
      {m_awvalid_o, m_wvalid_o, m_wlast_o, m_bready_o, m_arvalid_o, m_rready_o} <= 6'h0;
      m_wdata_o <= '0; m_wstrb_o <= '0;
      am_waitrequest_o <= 1'b1; am_readdata_o <= '0; am_readdatavalid_o <= 1'b0;
      av_address_o <= '0; av_read_o <= 1'b0; av_write_o <= 1'b0;
      av_writedata_o <= '0; av_byteenable_o <= '0;
    end else begin
      s_awready_o <= 1'b0;
      s_arready_o <= 1'b0;
      s_wready_o <= 1'b0;
      m_rready_o <= 1'b0;
      am_waitrequest_o <= 1'b1;
      am_readdatavalid_o <= 1'b0;
      // ready for b while the engine waits or avalon master writes are out
      m_bready_o <= ((st_r == axi_av_pkg::ST_XB) || tk.pend_nz) && !(m_bvalid_i && m_bready_o);
      case (st_r)
        axi_av_pkg::ST_IDLE: begin
          if (pk_aw || pk_ar || pk_am) begin
            src_axi_r <= !pk_am;
            wr_r <= c_wr;
            tgt_lav_r <= c_lav;
            addr_r <= c_addr;
            id_r <= c_id;
            cnt_r <= c_len;
            size_r <= c_size;
            burst_r <= c_burst;
            x_addr_r <= c_addr;
            x_id_r <= (`XS_REORDER > 1) ? '0 : c_id;
            x_len_r <= c_len;
            x_size_r <= c_size;
            x_burst_r <= c_burst;
            x_lock_r <= c_lock;
            x_cache_r <= c_cache;
            x_prot_r <= c_prot;
            s_awready_o <= pk_aw;
            s_arready_o <= pk_ar;
            m_wdata_o <= am_writedata_i;
            m_wstrb_o <= am_byteenable_i;
            m_wlast_o <= 1'b1;
            av_address_o <= {c_addr[`AVW-1:2], 2'b00};
            av_byteenable_o <= pk_am ? am_byteenable_i : be_of(c_size, c_addr[1:0]);
            av_writedata_o <= am_writedata_i;
            am_waitrequest_o <= !(pk_am && am_read_i);
            if (!c_lav) begin
              m_awvalid_o <= c_wr;
              m_arvalid_o <= !c_wr;
              st_r <= c_wr ? axi_av_pkg::ST_XAW : axi_av_pkg::ST_XAR;
            end else if (c_wr && !pk_am) begin
              st_r <= axi_av_pkg::ST_LWD;
            end else begin
              av_write_o <= c_wr;
              av_read_o <= !c_wr;
              st_r <= axi_av_pkg::ST_LCMD;
            end
          end
        end
        axi_av_pkg::ST_XAW: begin
          if (m_awready_i) begin
            m_awvalid_o <= 1'b0;
            m_wvalid_o <= !src_axi_r;
            st_r <= axi_av_pkg::ST_XW;
          end
        end
        axi_av_pkg::ST_XW: begin
          if (m_wvalid_o) begin
            if (m_wready_i) begin
              m_wvalid_o <= 1'b0;
              if (m_wlast_o && src_axi_r) begin
                st_r <= axi_av_pkg::ST_XB;
              end else if (m_wlast_o) begin
                am_waitrequest_o <= 1'b0;
                st_r <= axi_av_pkg::ST_IDLE;
              end
            end
          end else if (s_wvalid_i && s_wready_o) begin
            m_wdata_o <= s_wdata_i;
            m_wstrb_o <= s_wstrb_i;
            m_wlast_o <= s_wlast_i;
            m_wvalid_o <= 1'b1;
          end else begin
            s_wready_o <= 1'b1;
          end
        end
        axi_av_pkg::ST_XB: begin
          if (m_bvalid_i && m_bready_o) begin
            s_bresp_o <= m_bresp_i;
            s_bid_o <= id_r;
            s_bvalid_o <= 1'b1;
            st_r <= axi_av_pkg::ST_BRSP;
          end
        end
        axi_av_pkg::ST_XAR: begin
          if (m_arready_i) begin
            m_arvalid_o <= 1'b0;
            st_r <= axi_av_pkg::ST_XR;
          end
        end
        axi_av_pkg::ST_XR: begin
          if (m_rvalid_i && m_rready_o) begin
            s_rdata_o <= m_rdata_i;
            s_rresp_o <= m_rresp_i;
            s_rid_o <= id_r;
            s_rlast_o <= (cnt_r == 4'h0);
            s_rvalid_o <= src_axi_r;
            am_readdata_o <= m_rdata_i;
            am_readdatavalid_o <= !src_axi_r;
            cnt_r <= cnt_r - 4'h1;
            st_r <= src_axi_r ? axi_av_pkg::ST_RSP : axi_av_pkg::ST_IDLE;
          end else begin
            m_rready_o <= 1'b1;
          end
        end
        axi_av_pkg::ST_LWD: begin
          if (s_wvalid_i && s_wready_o) begin
            av_writedata_o <= s_wdata_i;
            av_byteenable_o <= be_of(size_r, addr_r[1:0]);
            av_address_o <= {addr_r[`AVW-1:2], 2'b00};
            av_write_o <= 1'b1;
            st_r <= axi_av_pkg::ST_LCMD;
          end else begin
            s_wready_o <= 1'b1;
          end
        end
        axi_av_pkg::ST_LCMD: begin
          if (!av_waitrequest_i) begin
            av_write_o <= 1'b0;
            av_read_o <= 1'b0;
            addr_r <= next_addr(addr_r, size_r, burst_r);
            if (!wr_r) begin
              st_r <= axi_av_pkg::ST_LRD;
            end else if (!src_axi_r) begin
              am_waitrequest_o <= 1'b0;
              st_r <= axi_av_pkg::ST_IDLE;
            end else if (cnt_r == 4'h0) begin
              s_bresp_o <= `RESP_OKAY;
              s_bid_o <= id_r;
              s_bvalid_o <= 1'b1;
              st_r <= axi_av_pkg::ST_BRSP;
            end else begin
              cnt_r <= cnt_r - 4'h1;
              st_r <= axi_av_pkg::ST_LWD;
            end
          end
        end
        axi_av_pkg::ST_LRD: begin
          if (av_readdatavalid_i) begin
            s_rdata_o <= av_readdata_i;
            s_rresp_o <= `RESP_OKAY;
            s_rid_o <= id_r;
            s_rlast_o <= (cnt_r == 4'h0);
            s_rvalid_o <= src_axi_r;
            am_readdata_o <= av_readdata_i;
            am_readdatavalid_o <= !src_axi_r;
            cnt_r <= cnt_r - 4'h1;
            st_r <= src_axi_r ? axi_av_pkg::ST_RSP : axi_av_pkg::ST_IDLE;
          end
        end
        axi_av_pkg::ST_RSP: begin
          if (s_rready_i) begin
            s_rvalid_o <= 1'b0;
            if (s_rlast_o) begin
              st_r <= axi_av_pkg::ST_IDLE;
            end else if (tgt_lav_r) begin
              // next beat, narrow or full width, goes out as its own single read
              av_address_o <= {addr_r[`AVW-1:2], 2'b00};
              av_byteenable_o <= be_of(size_r, addr_r[1:0]);
              av_read_o <= 1'b1;
              st_r <= axi_av_pkg::ST_LCMD;
            end else begin
              st_r <= axi_av_pkg::ST_XR;
            end
          end
        end
        axi_av_pkg::ST_BRSP: begin
          if (s_bready_i) begin
            s_bvalid_o <= 1'b0;
            st_r <= axi_av_pkg::ST_IDLE;
          end
        end
        default: st_r <= axi_av_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  function automatic logic be_contig(input logic [`SW-1:0] b);
    be_contig = b inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hc, 4'h7, 4'he, 4'hf};
  endfunction : be_contig

  property p_cache_pass;
    $rose(m_awvalid_o) && src_axi_r |-> m_awcache_o == $past(s_awcache_i) && m_awlen_o == $past(s_awlen_i);
  endproperty
  a_cache_pass: assert property (p_cache_pass) else $error("cache or length altered");

  property p_prot_pass;
    $rose(m_arvalid_o) && src_axi_r |-> m_arprot_o == $past(s_arprot_i) && m_araddr_o == $past(s_araddr_i);
  endproperty
  a_prot_pass: assert property (p_prot_pass) else $error("prot or address altered");

  property p_id_const;
    m_arvalid_o || m_awvalid_o |-> (`XS_REORDER <= 1) || (x_id_r == '0);
  endproperty
  a_id_const: assert property (p_id_const) else $error("id not zero to reordering slave");

  property p_am_attr;
    $rose(m_awvalid_o) && !src_axi_r |-> m_awcache_o == `AM_CACHE && m_awlock_o == `LOCK_NONE ##1 !am_readdatavalid_o;
  endproperty
  a_am_attr: assert property (p_am_attr) else $error("avalon master attributes not cleared");

  property p_av_align;
    av_read_o || av_write_o |-> av_address_o[1:0] == 2'h0 && be_contig(av_byteenable_o);
  endproperty
  a_av_align: assert property (p_av_align) else $error("avalon command unaligned or split lanes");

  property p_strict;
    $rose(m_arvalid_o) && !src_axi_r |-> (`STRICT_ORD == 0) || !$past(tk.pend_nz);
  endproperty
  a_strict: assert property (p_strict) else $error("read passed pending writes");

  property p_one_slave;
    $rose(av_read_o) || $rose(av_write_o) |-> !$past(tk.pend_nz);
  endproperty
  a_one_slave: assert property (p_one_slave) else $error("second slave addressed while pending");

  property p_b_final;
    $rose(s_bvalid_o) && !tgt_lav_r |-> $past(m_bvalid_i && m_bready_o) && s_bresp_o == $past(m_bresp_i);
  endproperty
  a_b_final: assert property (p_b_final) else $error("write response not from final slave");

  property p_lav_okay;
    (s_bvalid_o || s_rvalid_o) && tgt_lav_r |-> (s_bvalid_o ? s_bresp_o : s_rresp_o) == `RESP_OKAY;
  endproperty
  a_lav_okay: assert property (p_lav_okay) else $error("avalon slave answer not okay");

  c_lav_burst: cover property (s_rvalid_o && s_rlast_o && tgt_lav_r && x_len_r != 4'h0);
  c_am_wr_x: cover property (tk.issue);
  c_axi_wr_x: cover property ($rose(s_bvalid_o) && !tgt_lav_r);
  c_am_rd_lav: cover property (am_readdatavalid_o && tgt_lav_r);
endmodule : axi3_avalon_interconnect_adapt

//--- pkg/axi_av_cfg.svh
// widths, field codes and build options of the axi3/avalon adapter
`ifndef AXI_AV_CFG_SVH
`define AXI_AV_CFG_SVH
`define AW          64
`define IDW         18
`define DW          32
`define SW          4
`define AVW         32
`define TGT_BIT     31
`define CNT_W       4
`define XS_REORDER  1
`define STRICT_ORD  1
`define RESP_OKAY   2'h0
`define BURST_FIXED 2'h0
`define BURST_INCR  2'h1
`define LOCK_NONE   2'h0
`define AM_CACHE    4'h0
`define AM_PROT     3'h0
`define AM_SIZE     3'h2
`endif

//--- pkg/axi_av_pkg.sv
// types shared by the adapter modules
`include "axi_av_cfg.svh"
package axi_av_pkg;
  typedef logic [`IDW-1:0] id_t;
  typedef logic [`AW-1:0]  addr_t;
  typedef enum logic [3:0] {
    ST_IDLE, ST_XAW, ST_XW, ST_XB, ST_XAR, ST_XR,
    ST_LWD, ST_LCMD, ST_LRD, ST_RSP, ST_BRSP
  } eng_st_t;
endpackage : axi_av_pkg

//--- pkg/trk_if.sv
// link between the command engine and the outstanding tracker
interface trk_if;
  logic issue;
  logic retire;
  logic tgt_lav;
  logic stall;
  logic pend_nz;
  logic full;
  modport user (output issue, output retire, output tgt_lav, input stall, input pend_nz, input full);
  modport trk  (input issue, input retire, input tgt_lav, output stall, output pend_nz, output full);
endinterface : trk_if

//--- core/out_tracker.sv
// outstanding response counter with single-target tracking
`include "axi_av_cfg.svh"
module out_tracker (
  input wire logic mclk_i,
  input wire logic resetn_i,
  trk_if.trk       tk
);
  logic [`CNT_W-1:0] cnt_r;
  logic              cur_r;

  // count issues minus retires, remember the slave they went to
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_r <= '0;
      cur_r <= 1'b0;
    end else begin
      if (tk.issue && !tk.retire) begin
        cnt_r <= cnt_r + `CNT_W'(1);
      end else if (tk.retire && !tk.issue) begin
        cnt_r <= cnt_r - `CNT_W'(1);
      end
      if (tk.issue) begin
        cur_r <= tk.tgt_lav;
      end
    end
  end

  // another slave may only be addressed once all responses are back
  assign tk.pend_nz = (cnt_r != '0);
  assign tk.full    = &cnt_r;
  assign tk.stall   = tk.pend_nz && (tk.tgt_lav != cur_r);
endmodule : out_tracker

//--- verif/axi_av_far.sv
// far side model: one axi slave and one avalon slave
module axi_av_far (
  input  wire logic        mclk_i, resetn_i, m_awvalid_o, m_wvalid_o, m_wlast_o, m_bready_o,
  input  wire logic        m_arvalid_o, m_rready_o, av_read_o, av_write_o,
  input  wire logic [3:0]  m_arlen_o,
  output logic             m_awready_i, m_wready_i, m_bvalid_i, m_arready_i, m_rvalid_i,
  output logic             av_waitrequest_i, av_readdatavalid_i,
  output logic [1:0]       m_bresp_i, m_rresp_i,
  output logic [31:0]      m_rdata_i, av_readdata_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] left_r; // read beats still owed
  // readies come a cycle late, answers wait to be taken, idle lines keep toggling
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {m_awready_i, m_wready_i, m_bvalid_i, m_arready_i, m_rvalid_i, av_readdatavalid_i, left_r} <= '0;
      {av_waitrequest_i, m_bresp_i, m_rresp_i, m_rdata_i, av_readdata_i} <= '1;
    end else begin
      m_awready_i <= m_awvalid_o & ~m_awready_i;
      m_wready_i <= m_wvalid_o & ~m_wready_i;
      m_arready_i <= m_arvalid_o & ~m_arready_i;
      av_waitrequest_i <= ~((av_read_o | av_write_o) & av_waitrequest_i);
      av_readdatavalid_i <= av_read_o & ~av_waitrequest_i;
      av_readdata_i <= (av_read_o & ~av_waitrequest_i) ? 32'h5a5a_0000 : ~av_readdata_i;
      if (!m_bvalid_i) m_bresp_i <= ~m_bresp_i;
      if (m_bvalid_i & m_bready_o) m_bvalid_i <= 1'b0;
      if (m_wvalid_o & m_wready_i & m_wlast_o) begin
        m_bvalid_i <= 1'b1;
        m_bresp_i <= 2'h1;
      end
      if (!m_rvalid_i) {m_rdata_i, m_rresp_i} <= ~{m_rdata_i, m_rresp_i};
      if (m_rvalid_i & m_rready_o) begin
        m_rvalid_i <= left_r != 4'h0;
        left_r <= left_r - 4'h1;
      end
      if (m_arvalid_o & m_arready_i) begin
        {m_rvalid_i, left_r, m_rdata_i, m_rresp_i} <= {1'b1, m_arlen_o, 32'h5a5a_0000, 2'h1};
      end
    end
  end
endmodule : axi_av_far

//--- verif/tb_axi3_avalon_interconnect_adapt.sv
// self-checking bench for the axi3 and avalon adapter
module tb_axi3_avalon_interconnect_adapt;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_i = 1'b0, resetn_i = 1'b1, s_awvalid_i, s_wvalid_i, s_wlast_i, s_bready_i, s_arvalid_i, s_rready_i;
  logic am_read_i, am_write_i, s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o, s_rlast_o, m_awvalid_o;
  logic m_wvalid_o, m_wlast_o, m_bready_o, m_arvalid_o, m_rready_o, am_waitrequest_o, am_readdatavalid_o, av_read_o;
  logic av_write_o, m_awready_i, m_wready_i, m_bvalid_i, m_arready_i, m_rvalid_i, av_waitrequest_i, av_readdatavalid_i;
  axi_av_pkg::id_t s_awid_i, s_arid_i, s_bid_o, s_rid_o, m_awid_o, m_arid_o;
  axi_av_pkg::addr_t s_awaddr_i, s_araddr_i, m_awaddr_o, m_araddr_o;
  logic [3:0] s_awlen_i, s_arlen_i, s_awcache_i, s_arcache_i, m_awlen_o, m_arlen_o, m_awcache_o, m_arcache_o;
  logic [2:0] s_awsize_i, s_arsize_i, s_awprot_i, s_arprot_i, m_awsize_o, m_arsize_o, m_awprot_o, m_arprot_o;
  logic [1:0] s_awburst_i, s_arburst_i, s_awlock_i, s_arlock_i, m_awburst_o, m_arburst_o, m_awlock_o, m_arlock_o;
  logic [1:0] s_bresp_o, s_rresp_o, m_bresp_i, m_rresp_i;
  logic [3:0] s_wstrb_i, am_byteenable_i, m_wstrb_o, av_byteenable_o;
  logic [31:0] s_wdata_i, s_rdata_o, m_wdata_o, m_rdata_i, am_writedata_i, am_readdata_o, av_writedata_o, av_readdata_i;
  logic [31:0] am_address_i, av_address_o;
  int n_errors = 0, num_checks = 0;
  // rows: address, cache, prot, lock, then the expected write response
  logic [74:0] rows [4] = '{{64'hfedc_0000_0000_0040, 4'h0, 3'h0, 2'h0, 2'h1}, {64'h124, 4'hf, 3'h7, 2'h1, 2'h1},
    {64'h8000_0006, 4'ha, 3'h5, 2'h1, 2'h0}, {64'h8000_0013, 4'h3, 3'h2, 2'h0, 2'h0}};
  axi3_avalon_interconnect_adapt axi3_avalon_interconnect_adapt_inst (.*);
  axi_av_far axi_av_far_inst (.*);
  always #2.5 mclk_i = ~mclk_i;
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // bounded wait for a level, then the run is cut short
  task automatic wt(ref logic f, input logic v);
    int i;
    for (i = 0; i < 300 && f !== v; i++) @(posedge mclk_i) #1;
    if (f !== v) begin
      n_errors++;
      end_of_test();
    end
  endtask : wt
  task automatic wr(input logic [74:0] r);
    @(posedge mclk_i);
    {s_awaddr_i, s_awcache_i, s_awprot_i, s_awlock_i, s_awid_i, s_awvalid_i} <= {r[74:2], r[28:11], 1'b1};
    #1 wt(s_awready_o, 1'b1);
    if (!r[42]) chk("aw", {r[10:2], r[28:11]}, {m_awcache_o, m_awprot_o, m_awlock_o, m_awid_o});
    if (!r[42]) chk("awaddr", r[74:11], m_awaddr_o);
    @(posedge mclk_i);
    {s_awvalid_i, s_wvalid_i, s_wdata_i} <= {2'b01, r[42:11]};
    #1 wt(s_wready_o, 1'b1);
    @(posedge mclk_i);
    s_wvalid_i <= 1'b0;
    #1 if (r[42]) wt(av_write_o, 1'b1);
    if (r[42]) chk("av wr", {r[42:13], 2'h0, 4'hf}, {av_address_o, av_byteenable_o});
    wt(s_bvalid_o, 1'b1);
    chk("b", {r[1:0], r[28:11]}, {s_bresp_o, s_bid_o});
  endtask : wr
  task automatic rd(input logic [63:0] a, input logic [1:0] e);
    int b;
    @(posedge mclk_i);
    {s_araddr_i, s_arlen_i, s_arvalid_i} <= {a, 5'h3};
    #1 wt(s_arready_o, 1'b1);
    if (!a[31]) chk("araddr", a, m_araddr_o);
    @(posedge mclk_i);
    s_arvalid_i <= 1'b0;
    for (b = 0; b < 2; b++) begin
      #1 if (a[31]) wt(av_read_o, 1'b1);
      if (a[31]) chk("av rd", {a[31:2], 2'h0} + 4 * b, av_address_o);
      wt(s_rvalid_o, 1'b1);
      chk("r", {e, b[0]}, {s_rresp_o, s_rlast_o});
      @(posedge mclk_i);
    end
  endtask : rd
  initial begin
    {s_awvalid_i, s_wvalid_i, s_arvalid_i, am_read_i, am_write_i, s_awlen_i, s_awid_i, s_arid_i, am_address_i} = '0;
    {s_arcache_i, s_arprot_i, s_arlock_i, s_awaddr_i, s_araddr_i, s_wdata_i, am_writedata_i, s_arlen_i} = '0;
    {s_awsize_i, s_arsize_i, s_awburst_i, s_arburst_i, s_wlast_i, s_bready_i, s_rready_i} = 13'h92f;
    {s_awcache_i, s_awprot_i, s_awlock_i, s_wstrb_i, am_byteenable_i} = 17'h000ff;
    resetn_i = 1'b0;
    repeat (8) @(posedge mclk_i);
    #1 chk("reset", 5'h10, {am_waitrequest_o, s_awready_o, m_awvalid_o, av_read_o, s_bvalid_o});
    @(posedge mclk_i);
    resetn_i <= 1'b1;
    foreach (rows[k]) wr(rows[k]);
    rd(64'h100, 2'h1);
    rd(64'h8000_0001, 2'h0);
    @(posedge mclk_i);
    {am_address_i, am_write_i} <= {32'h200, 1'b1};
    #1 wt(m_awvalid_o, 1'b1);
    chk("am attr", 12'h002, {m_awcache_o, m_awprot_o, m_awlock_o, m_awsize_o});
    wt(am_waitrequest_o, 1'b0);
    @(posedge mclk_i);
    {am_write_i, am_read_i} <= 2'b01;
    #1 wt(am_waitrequest_o, 1'b0);
    @(posedge mclk_i);
    am_read_i <= 1'b0;
    #1 wt(am_readdatavalid_o, 1'b1);
    chk("am rdata", 32'h5a5a_0000, am_readdata_o);
    end_of_test();
  end
endmodule : tb_axi3_avalon_interconnect_adapt
